// ==== hdl/cpu_sfr.sv ====
// core special registers: bank select, working register, program counter low, lookup, status
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module cpu_sfr #(
    parameter int BANK_BITS = 3,
    parameter int PC_WIDTH  = 14
) (
    input  wire logic                CLK,
    input  wire logic                SYS_RST,
    input  wire logic                WDOG_RST,
    input  wire logic [7:0]          ADDR,
    input  wire logic [7:0]          WDATA,
    input  wire logic                WR,
    input  wire logic                RD,
    output logic [7:0]               RDATA,
    input  wire logic                MEM_INDIRECT,
    input  wire logic [7:0]          PROG_LOW_BYTE,
    input  wire logic [7:0]          PROG_HIGH_BYTE,
    output logic [PC_WIDTH-1:0]      PROG_ADDR,
    output logic [PC_WIDTH-1:0]      TABLE_ADDR,
    output logic                     JUMP,
    output logic                     STALL,
    output logic [2:0]               DATA_BANK,
    output logic                     BANK_VALID
);
    // ======================================================
    // elaboration check
    // refused at elaboration, not at run time, so a bad variant never builds
    if (BANK_BITS != 1 && BANK_BITS != 2 && BANK_BITS != 3) begin : g_bank_bits_bad
        $error("BANK_BITS must be 1, 2 or 3");
    end
    if (PC_WIDTH < 9 || PC_WIDTH > 16) begin : g_pc_width_bad
        $error("PC_WIDTH out of range");
    end

    // ======================================================
    // bus decode
    cpu_sfr_pkg::bus_req_t   req;
    assign req = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

    // ======================================================
    // register state
    logic [7:0]                bank_ff, nxt_bank;
    logic [7:0]                work_ff, nxt_work;
    logic [7:0]                ptr_lo_ff, nxt_ptr_lo;
    logic [7:0]                ptr_hi_ff, nxt_ptr_hi;
    logic [7:0]                res_hi_ff, nxt_res_hi;
    logic [7:0]                pc_hi_ff, nxt_pc_hi;
    logic [7:0]                pcl_ff, nxt_pcl;
    cpu_sfr_pkg::status_t      st_ff, nxt_st;
    logic                      halted_ff, nxt_halted;
    cpu_sfr_pkg::seq_state_t   seq_ff, nxt_seq;
    logic [7:0]                rdata_ff, nxt_rdata;
    logic                      jump_ff, nxt_jump;
    logic                      stall_ff, nxt_stall;
    logic [7:0]                map_ff, nxt_map;
    logic                      map_ok_ff, nxt_map_ok;

    // ======================================================
    // bank select masks per variant
    logic [7:0] bank_mask;
    logic       bank_code_ok;
    always_comb begin
        case (BANK_BITS)
            1: bank_mask = 8'h01;
            2: bank_mask = 8'h03;
            // program bank bit plus data field
            default: bank_mask = 8'h27;
        endcase
    end

    always_comb begin
        case (BANK_BITS)
            1: bank_code_ok = 1'b1;
            2: bank_code_ok = (bank_ff[1:0] != 2'h3);
            default: bank_code_ok = (bank_ff[2:0] <= 3'h4);
        endcase
    end

    // ======================================================
    // alu
    logic [8:0]                alu_sum;
    logic [4:0]                nib_sum;
    logic [7:0]                alu_res;
    logic                      alu_carry, alu_nib, alu_wrap, carry_in7;
    logic                      alu_arith, alu_logic;
    cpu_sfr_pkg::alu_op_t      op;
    logic                      alu_go;
    assign op     = cpu_sfr_pkg::alu_op_t'(req.wdata[2:0]);
    assign alu_go = req.wr && req.addr == cpu_sfr_pkg::OFF_ALU_CMD;
    always_comb begin
        alu_sum   = 9'h000;
        nib_sum   = 5'h00;
        alu_res   = work_ff;
        alu_carry = st_ff.carry;
        alu_nib   = st_ff.nib;
        alu_arith = 1'b0;
        alu_logic = 1'b0;
        carry_in7 = 1'b0;
        // operand B is the memory byte presented with the command
        case (op)
            cpu_sfr_pkg::ALU_ADD: begin
                alu_sum   = {1'b0, work_ff} + {1'b0, PROG_LOW_BYTE};
                nib_sum   = {1'b0, work_ff[3:0]} + {1'b0, PROG_LOW_BYTE[3:0]};
                carry_in7 = (work_ff[6:0] + PROG_LOW_BYTE[6:0]) > 8'h7F;
                alu_res   = alu_sum[7:0];
                alu_carry = alu_sum[8];
                alu_nib   = nib_sum[4];
                alu_arith = 1'b1;
            end
            cpu_sfr_pkg::ALU_SUB: begin
                alu_sum   = {1'b0, work_ff} + {1'b0, ~PROG_LOW_BYTE} + 9'h001;
                nib_sum   = {1'b0, work_ff[3:0]} + {1'b0, ~PROG_LOW_BYTE[3:0]} + 5'h01;
                carry_in7 = ({1'b0, work_ff[6:0]} + {1'b0, ~PROG_LOW_BYTE[6:0]}
                             + 8'h01) > 8'h7F;
                alu_res   = alu_sum[7:0];
                alu_carry = alu_sum[8];
                alu_nib   = nib_sum[4];
                alu_arith = 1'b1;
            end
            cpu_sfr_pkg::ALU_AND: begin
                alu_res   = work_ff & PROG_LOW_BYTE;
                alu_logic = 1'b1;
            end
            cpu_sfr_pkg::ALU_OR: begin
                alu_res   = work_ff | PROG_LOW_BYTE;
                alu_logic = 1'b1;
            end
            cpu_sfr_pkg::ALU_XOR: begin
                alu_res   = work_ff ^ PROG_LOW_BYTE;
                alu_logic = 1'b1;
            end
            cpu_sfr_pkg::ALU_RLC: begin
                alu_res   = {work_ff[6:0], st_ff.carry};
                alu_carry = work_ff[7];
            end
            cpu_sfr_pkg::ALU_RRC: begin
                alu_res   = {st_ff.carry, work_ff[7:1]};
                alu_carry = work_ff[0];
            end
            default: begin
                alu_res   = PROG_LOW_BYTE;
            end
        endcase
        // carry into msb differs from out
        alu_wrap = carry_in7 ^ alu_sum[8];
    end

    // ======================================================
    // register next values
    logic kick, halt_ev, tmo_ev, tbl_ev;
    assign kick    = req.wr && req.addr == cpu_sfr_pkg::OFF_EVENT
                     && req.wdata[cpu_sfr_pkg::EV_KICK_BIT];
    assign halt_ev = req.wr && req.addr == cpu_sfr_pkg::OFF_EVENT
                     && req.wdata[cpu_sfr_pkg::EV_HALT_BIT];
    assign tmo_ev  = req.wr && req.addr == cpu_sfr_pkg::OFF_EVENT
                     && req.wdata[cpu_sfr_pkg::EV_TIMEOUT_BIT];
    assign tbl_ev  = req.wr && req.addr == cpu_sfr_pkg::OFF_EVENT
                     && req.wdata[cpu_sfr_pkg::EV_TBLRD_BIT];

    always_comb begin
        nxt_bank   = bank_ff;
        nxt_work   = work_ff;
        nxt_ptr_lo = ptr_lo_ff;
        nxt_ptr_hi = ptr_hi_ff;
        nxt_res_hi = res_hi_ff;
        nxt_pc_hi  = pc_hi_ff;
        nxt_pcl    = pcl_ff;
        nxt_st     = st_ff;
        nxt_halted = halted_ff;
        nxt_jump   = 1'b0;
        nxt_map    = map_ff;
        nxt_map_ok = map_ok_ff;
        if (req.wr) begin
            case (req.addr)
                cpu_sfr_pkg::OFF_BANK_SEL: nxt_bank = req.wdata & bank_mask;
                cpu_sfr_pkg::OFF_WORKING:  nxt_work = req.wdata;
                cpu_sfr_pkg::OFF_PTR_LOW:  nxt_ptr_lo = req.wdata;
                cpu_sfr_pkg::OFF_PTR_HIGH: nxt_ptr_hi = req.wdata;
                cpu_sfr_pkg::OFF_PC_HIGH:  nxt_pc_hi = req.wdata;
                cpu_sfr_pkg::OFF_PCL: begin
                    // page kept, only low byte loaded
                    nxt_pcl  = req.wdata;
                    nxt_jump = 1'b1;
                end
                cpu_sfr_pkg::OFF_STATUS: begin
                    nxt_st.wrap  = req.wdata[cpu_sfr_pkg::ST_WRAP_BIT];
                    nxt_st.zero  = req.wdata[cpu_sfr_pkg::ST_ZERO_BIT];
                    nxt_st.nib   = req.wdata[cpu_sfr_pkg::ST_NIB_BIT];
                    nxt_st.carry = req.wdata[cpu_sfr_pkg::ST_CARRY_BIT];
                end
                cpu_sfr_pkg::OFF_ADDR_MAP: begin
                    nxt_map = req.wdata;
                    // direct path always mapped, indirect path needs a valid bank code
                    nxt_map_ok = !MEM_INDIRECT || bank_code_ok;
                end
                default: ;
            endcase
        end
        if (alu_go) begin
            nxt_work     = alu_res;
            nxt_st.carry = alu_carry;
            nxt_st.nib   = alu_nib;
            if (alu_arith) begin
                nxt_st.wrap = alu_wrap;
            end
            if (alu_arith || alu_logic) begin
                nxt_st.zero = (alu_res == 8'h00);
            end
        end
        if (tbl_ev) begin
            // high byte latched, low to working
            nxt_res_hi = PROG_HIGH_BYTE;
            nxt_work   = PROG_LOW_BYTE;
        end
        if (halt_ev) begin
            nxt_st.halt = 1'b1;
            nxt_halted  = 1'b1;
        end
        if (kick) begin
            nxt_st.halt = 1'b0;
            nxt_halted  = 1'b0;
        end
        // kick or halt clear, timeout sets and wins
        if (kick || halt_ev) begin
            nxt_st.wdog = 1'b0;
        end
        if (tmo_ev) begin
            nxt_st.wdog = 1'b1;
        end
        // watchdog reset while sleeping keeps the bank
        if (WDOG_RST && !halted_ff) begin
            nxt_bank = nxt_bank & ~8'h07;
        end
        if (WDOG_RST) begin
            nxt_halted = 1'b0;
        end
        // no save of status on calls or interrupts
    end

    // ======================================================
    // jump sequencer
    always_comb begin
        nxt_stall = 1'b0;
        nxt_seq   = seq_ff;
        case (seq_ff)
            cpu_sfr_pkg::RUN_ST: begin
                if (nxt_jump) begin
                    // one dummy cycle after low byte write
                    nxt_seq   = cpu_sfr_pkg::DUMMY_ST;
                    nxt_stall = 1'b1;
                end
            end
            cpu_sfr_pkg::DUMMY_ST: begin
                nxt_seq = cpu_sfr_pkg::RUN_ST;
            end
            default: nxt_seq = cpu_sfr_pkg::RUN_ST;
        endcase
    end

    // ======================================================
    // read mux
    always_comb begin
        nxt_rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                cpu_sfr_pkg::OFF_BANK_SEL: nxt_rdata = bank_ff & bank_mask;
                cpu_sfr_pkg::OFF_WORKING:  nxt_rdata = work_ff;
                cpu_sfr_pkg::OFF_PCL:      nxt_rdata = pcl_ff;
                cpu_sfr_pkg::OFF_PTR_LOW:  nxt_rdata = ptr_lo_ff;
                cpu_sfr_pkg::OFF_PTR_HIGH: nxt_rdata = ptr_hi_ff;
                cpu_sfr_pkg::OFF_RES_HIGH: nxt_rdata = res_hi_ff;
                cpu_sfr_pkg::OFF_PC_HIGH:  nxt_rdata = pc_hi_ff;
                cpu_sfr_pkg::OFF_STATUS:   nxt_rdata = {2'b00, st_ff};
                cpu_sfr_pkg::OFF_ADDR_MAP:
                    nxt_rdata = map_ok_ff ? map_ff : cpu_sfr_pkg::UNDEF_BANK_RD;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // ======================================================
    // registers
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            bank_ff   <= cpu_sfr_pkg::RST_BANK_SEL;
            work_ff   <= cpu_sfr_pkg::RST_BYTE;
            ptr_lo_ff <= cpu_sfr_pkg::RST_BYTE;
            ptr_hi_ff <= cpu_sfr_pkg::RST_BYTE;
            res_hi_ff <= cpu_sfr_pkg::RST_BYTE;
            pc_hi_ff  <= cpu_sfr_pkg::RST_BYTE;
            pcl_ff    <= cpu_sfr_pkg::RST_BYTE;
            st_ff     <= cpu_sfr_pkg::RST_STATUS;
            halted_ff <= 1'b0;
            seq_ff    <= cpu_sfr_pkg::RUN_ST;
            rdata_ff  <= 8'h00;
            jump_ff   <= 1'b0;
            stall_ff  <= 1'b0;
            map_ff    <= cpu_sfr_pkg::RST_BYTE;
            map_ok_ff <= 1'b1;
        end else begin
            bank_ff   <= nxt_bank;
            work_ff   <= nxt_work;
            ptr_lo_ff <= nxt_ptr_lo;
            ptr_hi_ff <= nxt_ptr_hi;
            res_hi_ff <= nxt_res_hi;
            pc_hi_ff  <= nxt_pc_hi;
            pcl_ff    <= nxt_pcl;
            st_ff     <= nxt_st;
            halted_ff <= nxt_halted;
            seq_ff    <= nxt_seq;
            rdata_ff  <= nxt_rdata;
            jump_ff   <= nxt_jump;
            stall_ff  <= nxt_stall;
            map_ff    <= nxt_map;
            map_ok_ff <= nxt_map_ok;
        end
    end

    // ======================================================
    // outputs
    logic [PC_WIDTH-1:0] prog_addr_ff, tbl_addr_ff;
    logic [2:0]          dbank_ff;
    logic                bvalid_ff;
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            prog_addr_ff <= '0;
            tbl_addr_ff  <= '0;
            dbank_ff     <= 3'h0;
            bvalid_ff    <= 1'b1;
        end else begin
            // program bank bit forms address bit 13
            prog_addr_ff <= PC_WIDTH'({(BANK_BITS == 3) ? nxt_bank[cpu_sfr_pkg::BANK_PROG_BIT]
                                                        : 1'b0, 13'h0000})
                            | PC_WIDTH'({nxt_pc_hi[4:0], nxt_pcl});
            tbl_addr_ff  <= PC_WIDTH'({nxt_ptr_hi, nxt_ptr_lo});
            dbank_ff     <= nxt_bank[2:0];
            bvalid_ff    <= (BANK_BITS == 1) || ((BANK_BITS == 2) ? (nxt_bank[1:0] != 2'h3)
                                                                  : (nxt_bank[2:0] <= 3'h4));
        end
    end

    assign RDATA      = rdata_ff;
    assign JUMP       = jump_ff;
    assign STALL      = stall_ff;
    assign PROG_ADDR  = prog_addr_ff;
    assign TABLE_ADDR = tbl_addr_ff;
    assign DATA_BANK  = dbank_ff;
    assign BANK_VALID = bvalid_ff;
endmodule

// ==== hdl/cpu_sfr_pkg.sv ====
// package: register offsets, field positions, reset values and types for the core registers
package cpu_sfr_pkg;
    // ======================================================
    // register offsets (index into the special register space)
    localparam logic [7:0] OFF_WORKING   = 8'h05;
    localparam logic [7:0] OFF_PCL       = 8'h06;
    localparam logic [7:0] OFF_PTR_LOW   = 8'h07;
    localparam logic [7:0] OFF_PTR_HIGH  = 8'h08;
    localparam logic [7:0] OFF_RES_HIGH  = 8'h09;
    localparam logic [7:0] OFF_STATUS    = 8'h0A;
    localparam logic [7:0] OFF_BANK_SEL  = 8'h04;
    localparam logic [7:0] OFF_ALU_CMD   = 8'h0B;
    localparam logic [7:0] OFF_EVENT     = 8'h0C;
    localparam logic [7:0] OFF_PC_HIGH   = 8'h0D;
    localparam logic [7:0] OFF_ADDR_MAP  = 8'h0E;
    // ======================================================
    // field positions
    localparam int BANK_PROG_BIT   = 5;
    localparam int ST_WDOG_BIT     = 5;
    localparam int ST_HALT_BIT     = 4;
    localparam int ST_WRAP_BIT     = 3;
    localparam int ST_ZERO_BIT     = 2;
    localparam int ST_NIB_BIT      = 1;
    localparam int ST_CARRY_BIT    = 0;
    localparam int EV_KICK_BIT     = 0;
    localparam int EV_HALT_BIT     = 1;
    localparam int EV_TIMEOUT_BIT  = 2;
    localparam int EV_TBLRD_BIT    = 3;
    // ======================================================
    // reset values
    localparam logic [7:0] RST_BANK_SEL  = 8'h00;
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [5:0] RST_STATUS    = 6'h00;
    localparam logic [7:0] UNDEF_BANK_RD = 8'h00;
    // ======================================================
    // timing
    localparam int PCL_DUMMY_CYCLES = 1;
    // program address bounds for the wide variant
    localparam logic [13:0] PROG_BANK1_BASE = 14'h2000;
    // ======================================================
    // types
    typedef enum logic [2:0] {
        ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_RLC, ALU_RRC, ALU_MOV
    } alu_op_t;

    typedef enum {
        RUN_ST, DUMMY_ST
    } seq_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } bus_req_t;

    typedef struct packed {
        logic        wdog;
        logic        halt;
        logic        wrap;
        logic        zero;
        logic        nib;
        logic        carry;
    } status_t;
endpackage

// ==== verif/cpu_sfr_chk.sv ====
// checker: jump, read and bank relations at the core register ports
`timescale 1ns/1ps
module cpu_sfr_chk #(
    parameter int BANK_BITS = 3,
    parameter int PC_WIDTH  = 14
) (
    input  wire logic                CLK,
    input  wire logic                SYS_RST,
    input  wire logic [7:0]          ADDR,
    input  wire logic [7:0]          WDATA,
    input  wire logic                WR,
    input  wire logic                RD,
    input  wire logic [7:0]          RDATA,
    input  wire logic [PC_WIDTH-1:0] PROG_ADDR,
    input  wire logic                JUMP,
    input  wire logic                STALL,
    input  wire logic [2:0]          DATA_BANK,
    input  wire logic                BANK_VALID
);
    // ======================================================
    // helpers
    // bits that this variant leaves unimplemented
    localparam logic [7:0] UNUSED = (BANK_BITS == 3) ? 8'hD8 : (BANK_BITS == 2) ? 8'hFC : 8'hFE;
    logic pcl_wr;
    logic code_ok;
    assign pcl_wr  = WR && (ADDR == cpu_sfr_pkg::OFF_PCL);
    assign code_ok = (BANK_BITS == 3) ? (DATA_BANK <= 3'h4) :
                     (BANK_BITS == 2) ? (DATA_BANK != 3'h3) : 1'b1;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // ======================================================
    // assertions
    chk_jump_target: assert property (
        pcl_wr |=> JUMP && PROG_ADDR[7:0] == $past(WDATA)) else $error("pcl jump target wrong");
    chk_page_kept: assert property (
        pcl_wr |=> PROG_ADDR[PC_WIDTH-1:8] == $past(PROG_ADDR[PC_WIDTH-1:8]))
        else $error("pcl write left the page");
    chk_dummy_pulse: assert property (
        pcl_wr |=> STALL) else $error("no dummy cycle after pcl write");
    chk_no_stray_jump: assert property (
        !pcl_wr |=> !JUMP && !STALL) else $error("jump without pcl write");
    chk_read_idle: assert property (
        !RD |=> RDATA == 8'h00) else $error("read data outside read cycle");
    chk_bank_unused: assert property (
        RD && ADDR == cpu_sfr_pkg::OFF_BANK_SEL |=> (RDATA & UNUSED) == 8'h00
        && RDATA[2:0] == $past(DATA_BANK)) else $error("bank read wrong");
    chk_status_upper: assert property (
        RD && ADDR == cpu_sfr_pkg::OFF_STATUS |=> RDATA[7:6] == 2'b00)
        else $error("status upper bits set");
    chk_code_valid: assert property (
        BANK_VALID == code_ok) else $error("bank valid disagrees with code");
    chk_reset_bank: assert property (
        $past(SYS_RST) |-> DATA_BANK == 3'h0 && BANK_VALID && !JUMP)
        else $error("bank not cleared by reset");
    cov_jump: cover property (pcl_wr ##1 JUMP);
    cov_undef: cover property (!BANK_VALID);
    cov_status: cover property (RD && ADDR == cpu_sfr_pkg::OFF_STATUS);
endmodule
bind cpu_sfr cpu_sfr_chk #(.BANK_BITS(BANK_BITS), .PC_WIDTH(PC_WIDTH)) chk_i (
    .CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .PROG_ADDR(PROG_ADDR), .JUMP(JUMP), .STALL(STALL),
    .DATA_BANK(DATA_BANK), .BANK_VALID(BANK_VALID)
);

// ==== verif/tb_cpu_sfr.sv ====
// testbench: register access, alu flags, events and bank select of the core registers
`timescale 1ns/1ps
module tb_cpu_sfr;
    // ======================================================
    // signals
    logic                  clk;
    logic                  sys_rst;
    logic                  wdog_rst;
    logic                  mem_indirect;
    logic [7:0]            low_byte;
    logic [7:0]            high_byte;
    cpu_sfr_pkg::bus_req_t req;
    logic [7:0]            rdata;
    logic [13:0]           prog_addr;
    logic [13:0]           table_addr;
    logic                  jump;
    logic                  stall;
    logic [2:0]            data_bank;
    logic                  bank_valid;
    int                    err_count;
    int                    checks;
    logic [7:0]            v;
    logic [7:0]            w;
    logic [3:0]            fl;
    cpu_sfr DUT (
        .CLK(clk), .SYS_RST(sys_rst), .WDOG_RST(wdog_rst), .ADDR(req.addr), .WDATA(req.wdata),
        .WR(req.wr), .RD(req.rd), .RDATA(rdata), .MEM_INDIRECT(mem_indirect),
        .PROG_LOW_BYTE(low_byte), .PROG_HIGH_BYTE(high_byte), .PROG_ADDR(prog_addr),
        .TABLE_ADDR(table_addr), .JUMP(jump), .STALL(stall), .DATA_BANK(data_bank),
        .BANK_VALID(bank_valid)
    );
    initial clk = 1'b0;
    always #12.5 clk = ~clk;
    // ======================================================
    // tasks
    task automatic wrap_up();
        if (err_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] x);
        checks++;
        if (seen !== x) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, x, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 v = rdata;
        chk(n, 16'(v), 16'(x));
    endtask
    // status after an event; timeout wins over a clear in the same write
    task automatic ev(input logic [7:0] d, input logic [7:0] x);
        wr(cpu_sfr_pkg::OFF_EVENT, d);
        rdc("event status", cpu_sfr_pkg::OFF_STATUS, x);
    endtask
    task automatic probe(input logic ind, input logic [7:0] d, input logic [7:0] x);
        @(posedge clk) mem_indirect <= ind;
        wr(cpu_sfr_pkg::OFF_ADDR_MAP, d);
        rdc("map probe", cpu_sfr_pkg::OFF_ADDR_MAP, x);
    endtask
    task automatic wd(input logic [2:0] x);
        @(posedge clk) wdog_rst <= 1'b1;
        @(posedge clk) wdog_rst <= 1'b0;
        #1 chk("bank after watchdog", 16'(data_bank), 16'(x));
    endtask
    function automatic logic [11:0] alu_exp(input logic [2:0] op, input logic [7:0] a,
                                            input logic [7:0] b, input logic [3:0] fi);
        logic [7:0] m;
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] r;
        logic [3:0] f;
        f = fi;
        m = (op == 3'h1) ? ~b : b;
        s = {1'b0, a} + {1'b0, m} + {8'h00, op == 3'h1};
        h = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, op == 3'h1};
        case (op)
            3'h0, 3'h1: begin
                r = s[7:0];
                f = {s[8] ^ a[7] ^ m[7] ^ r[7], r == 8'h00, h[4], s[8]};
            end
            3'h2: r = a & b;
            3'h3: r = a | b;
            3'h4: r = a ^ b;
            3'h5: begin
                r = {a[6:0], fi[0]};
                f[0] = a[7];
            end
            3'h6: begin
                r = {fi[0], a[7:1]};
                f[0] = a[0];
            end
            default: r = b;
        endcase
        if (op >= 3'h2 && op <= 3'h4) f[2] = (r == 8'h00);
        return {f, r};
    endfunction
    task automatic alu(input logic [2:0] op, input logic [7:0] b);
        logic [11:0] e;
        logic [3:0]  msk;
        msk = (op < 3'h2) ? 4'hF : (op < 3'h5) ? 4'h4 : (op < 3'h7) ? 4'h1 : 4'h0;
        e = alu_exp(op, w, b, fl);
        w = e[7:0];
        fl = e[11:8];
        @(posedge clk) low_byte <= b;
        wr(cpu_sfr_pkg::OFF_ALU_CMD, {5'h00, op});
        rdc("working", cpu_sfr_pkg::OFF_WORKING, w);
        @(posedge clk) #1 chk("read idle", 16'(rdata), 16'h0000);
        // watchdog flag still set from the last timeout event
        rdc("status", cpu_sfr_pkg::OFF_STATUS, {4'h2, fl});
        chk("alu flags", 16'(v[3:0] & msk), 16'(fl & msk));
    endtask
    // ======================================================
    // sequence
    localparam logic [2:0] OPS [10] = '{3'h7, 3'h0, 3'h1, 3'h1, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    localparam logic [7:0] BS [10] = '{8'h7F, 8'h01, 8'h80, 8'h01, 8'hFF, 8'h0F, 8'h30, 8'h3E,
                                       8'h00, 8'h00};
    initial begin
        err_count = 0;
        checks = 0;
        sys_rst = 1'b1;
        wdog_rst = 1'b0;
        mem_indirect = 1'b0;
        low_byte = 8'h00;
        high_byte = 8'h00;
        req = '0;
        w = 8'h00;
        fl = 4'h0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        rdc("bank reset", cpu_sfr_pkg::OFF_BANK_SEL, cpu_sfr_pkg::RST_BANK_SEL);
        rdc("status reset", cpu_sfr_pkg::OFF_STATUS, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(cpu_sfr_pkg::OFF_BANK_SEL, {5'h1F, i[2:0]});
            chk("data bank", 16'(data_bank), 16'(i));
            chk("bank valid", 16'(bank_valid), 16'(i < 5));
            chk("prog bank", 16'(prog_addr[13]), 16'h0001);
            rdc("bank read", cpu_sfr_pkg::OFF_BANK_SEL, {5'h04, i[2:0]});
        end
        wr(cpu_sfr_pkg::OFF_BANK_SEL, 8'h07);
        chk("prog bank", 16'(prog_addr[13]), 16'h0000);
        probe(1'b0, 8'hA5, 8'hA5);
        probe(1'b1, 8'h5A, 8'h00);
        wr(cpu_sfr_pkg::OFF_BANK_SEL, 8'h02);
        probe(1'b1, 8'h3C, 8'h3C);
        @(posedge clk) sys_rst <= 1'b1;
        @(posedge clk) sys_rst <= 1'b0;
        #1 chk("bank after reset", 16'(data_bank), 16'h0000);
        wr(cpu_sfr_pkg::OFF_STATUS, 8'hFF);
        rdc("status write", cpu_sfr_pkg::OFF_STATUS, 8'h0F);
        wr(cpu_sfr_pkg::OFF_STATUS, 8'h00);
        wr(cpu_sfr_pkg::OFF_BANK_SEL, 8'h03);
        ev(8'h04, 8'h20);
        ev(8'h02, 8'h10);
        ev(8'h04, 8'h30);
        wr(cpu_sfr_pkg::OFF_STATUS, 8'h00);
        rdc("status write", cpu_sfr_pkg::OFF_STATUS, 8'h30);
        wd(3'h3);
        ev(8'h01, 8'h00);
        ev(8'h05, 8'h20);
        wd(3'h0);
        // table pointers are loaded before the read is issued
        wr(cpu_sfr_pkg::OFF_PTR_LOW, 8'h34);
        wr(cpu_sfr_pkg::OFF_PTR_HIGH, 8'h12);
        chk("table addr", 16'(table_addr), 16'h1234);
        @(posedge clk) high_byte <= 8'hC3;
        low_byte <= 8'h7E;
        wr(cpu_sfr_pkg::OFF_EVENT, 8'h08);
        rdc("table high", cpu_sfr_pkg::OFF_RES_HIGH, 8'hC3);
        rdc("table low", cpu_sfr_pkg::OFF_WORKING, 8'h7E);
        wr(cpu_sfr_pkg::OFF_BANK_SEL, 8'h20);
        wr(cpu_sfr_pkg::OFF_PC_HIGH, 8'h15);
        wr(cpu_sfr_pkg::OFF_PCL, 8'h9A);
        chk("jump", 16'({jump, stall}), 16'h0003);
        chk("jump target", 16'(prog_addr), 16'h359A);
        @(posedge clk) #1 chk("dummy end", 16'({jump, stall}), 16'h0000);
        rdc("unmapped", 8'h40, 8'h00);
        w = 8'h7E;
        fl = 4'h0;
        for (int i = 0; i < 10; i++) alu(OPS[i], BS[i]);
        wrap_up();
    end
    initial begin
        repeat (4000) @(posedge clk);
        err_count++;
        wrap_up();
    end
endmodule
